// ### rtl/hrcb_pkg.sv
/*
  Shared constants for the rotation sensor configuration bank: register
  offsets, field positions, reset values, timing counts and types.
  Assumes a byte-wide register port and one 250 MHz system clock.
*/
package hrcb_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] HRCB_ADDR_COMP_LO_A = 8'h74;
  localparam logic [7:0] HRCB_ADDR_COMP_LO_B = 8'h75;
  localparam logic [7:0] HRCB_ADDR_GAIN_A    = 8'h76;
  localparam logic [7:0] HRCB_ADDR_GAIN_B    = 8'h77;
  localparam logic [7:0] HRCB_ADDR_SIGN      = 8'h78;
  localparam logic [7:0] HRCB_ADDR_SINE      = 8'h79;
  localparam logic [7:0] HRCB_ADDR_COSINE    = 8'h7A;
  localparam logic [7:0] HRCB_ADDR_BETA      = 8'h7B;
  localparam logic [7:0] HRCB_ADDR_WAKE      = 8'h7C;
  localparam logic [7:0] HRCB_ADDR_INTERVAL  = 8'h7D;
  localparam logic [7:0] HRCB_ADDR_OFFS_HI   = 8'h7E;
  localparam logic [7:0] HRCB_ADDR_OFFS_LO   = 8'h7F;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int HRCB_COMP_HI_MSB = 7;
  localparam int HRCB_COMP_HI_LSB = 6;
  localparam int HRCB_COARSE_MSB  = 5;
  localparam int HRCB_COARSE_LSB  = 4;
  localparam int HRCB_FINE_MSB    = 3;
  localparam int HRCB_FINE_LSB    = 0;
  localparam int HRCB_OCT_MSB     = 6;
  localparam int HRCB_OCT_LSB     = 5;
  localparam int HRCB_INVERT_BIT  = 3;
  localparam int HRCB_RATIO_BIT   = 2;
  localparam int HRCB_DEN_BIT     = 1;
  localparam int HRCB_NUM_BIT     = 0;
  localparam int HRCB_THR_MSB     = 7;
  localparam int HRCB_THR_LSB     = 5;
  localparam int HRCB_PRE_MSB     = 4;
  localparam int HRCB_PRE_LSB     = 0;

  // ----------------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [7:0]  HRCB_RST_COMP_LO  = 8'h00;
  localparam logic [7:0]  HRCB_RST_GAIN     = 8'h00;
  localparam logic [7:0]  HRCB_RST_SINE     = 8'h00;
  localparam logic [7:0]  HRCB_RST_COSINE   = 8'h00;
  localparam logic [7:0]  HRCB_RST_BETA     = 8'h08;
  localparam logic [7:0]  HRCB_RST_WAKE     = 8'hFF;
  localparam logic [7:0]  HRCB_RST_INTERVAL = 8'h03;
  localparam logic [15:0] HRCB_RST_OFFSET   = 16'h0000;
  localparam logic [7:0]  HRCB_INTERVAL_MIN = 8'h0A;
  localparam logic [7:0]  HRCB_INTERVAL_MAX = 8'hB4;
  localparam logic [15:0] HRCB_OFFSET_MAX   = 16'h0167;
  localparam logic [4:0]  HRCB_AWAKE_LOAD   = 5'h1F;
  localparam logic [2:0]  HRCB_COUNT_MAX    = 3'h7;

  // ----------------------------------------------------------------------
  // timing: movement timer tick
  // ----------------------------------------------------------------------
  localparam int HRCB_CLK_PERIOD_NS = 4;
  localparam int HRCB_TICK_NS       = 1000;
  localparam int HRCB_TICK_CYCLES   = HRCB_TICK_NS / HRCB_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    HRCB_TUNE_OFF     = 2'h0,
    HRCB_TUNE_PARTIAL = 2'h1,
    HRCB_TUNE_SEMI    = 2'h2,
    HRCB_TUNE_FULL    = 2'h3
  } hrcb_tune_mode_t;

  typedef enum logic [1:0] {
    HRCB_SLEEP = 2'b01,
    HRCB_AWAKE = 2'b10
  } hrcb_wake_state_t;

endpackage : hrcb_pkg

// ### rtl/hrcb_top.sv
/*
  Configuration and result register bank of the two-plate rotation sensor.
  Assumes the serial register interface presents byte accesses on sys_clk
  and the tuning, angle and wheel logic share the same clock.
*/
// Behaviour
// - gain register bits 7-6 hold compensation 9-8
// - coarse gain bits 5-4, fine bits 3-0
// - read-only octant code in bits 6-5
// - bit 3 set reverses reported direction
// - read-only ratio/denominator/numerator sign flags
// - sine constant, phase sine times 255
// - cosine constant, phase cosine times 255
// - filter beta seeds wheel filter coefficient
// - wake if count reaches threshold first
// - nonzero preload starts each wake window
// - zero preload: stop asleep, 31 awake
// - interval size in degrees, 10 to 180
// - read-only 16-bit offset, 0 to 359
// - low compensation byte in own register
// - full tuning adjusts compensation, coarse, fine
// - wake mode wakes on channel zero touch
`timescale 1ns/100ps
`default_nettype none
module hrcb_top
  import hrcb_pkg::*;
#(
  parameter int TICK_CYCLES = HRCB_TICK_CYCLES
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // auto_gain_tuning engine
  input  wire logic [1:0]  tune_mode,
  input  wire logic        tune_we,
  input  wire logic        tune_pair_b,
  input  wire logic [9:0]  tune_comp,
  input  wire logic [1:0]  tune_coarse,
  input  wire logic [3:0]  tune_fine,
  // channel settings for sensor_pair_a and sensor_pair_b
  output logic      [9:0]  pair_a_comp,
  output logic      [1:0]  pair_a_coarse,
  output logic      [3:0]  pair_a_fine,
  output logic      [9:0]  pair_b_comp,
  output logic      [1:0]  pair_b_coarse,
  output logic      [3:0]  pair_b_fine,
  // angle calculation
  input  wire logic        calc_valid,
  input  wire logic [1:0]  calc_octant,
  input  wire logic        calc_ratio_neg,
  input  wire logic        calc_den_neg,
  input  wire logic        calc_num_neg,
  input  wire logic        calc_dir_raw,
  output logic      [7:0]  sine_const,
  output logic      [7:0]  cosine_const,
  output logic             dir_invert,
  output logic             angle_dir,
  // wheel filter
  input  wire logic        filt_restart,
  output logic      [7:0]  filt_coeff,
  // interval_output_function
  output logic      [7:0]  interval_deg,
  output logic             interval_ok,
  // wheel offset result
  input  wire logic        offset_valid,
  input  wire logic [15:0] offset_in,
  // wheel wake
  input  wire logic        wake_mode_en,
  input  wire logic        touch_channel_zero,
  input  wire logic        wheel_move,
  input  wire logic        wheel_sleep_req,
  output logic             wheel_awake,
  output logic             wheel_wake
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]  comp_lo_r [2];
  logic [7:0]  gain_r    [2];
  logic [1:0]  octant_r;
  logic        ratio_neg_r;
  logic        den_neg_r;
  logic        num_neg_r;
  logic        invert_r;
  logic [7:0]  sine_r;
  logic [7:0]  cosine_r;
  logic [7:0]  beta_r;
  logic [7:0]  wake_r;
  logic [7:0]  interval_r;
  logic [15:0] offset_r;
  logic [7:0]  rdata_nxt;
  logic        awake_r;
  logic        wake_r_pulse;

  hrcb_tune_mode_t mode;
  logic            tune_comp_en;
  logic            tune_coarse_en;
  logic            tune_fine_en;

  // the tuning engine only touches the fields its mode owns
  always_comb begin
    mode           = hrcb_tune_mode_t'(tune_mode);
    tune_comp_en   = tune_we && (mode != HRCB_TUNE_OFF);
    tune_fine_en   = tune_we && (mode == HRCB_TUNE_SEMI ||
                                 mode == HRCB_TUNE_FULL);
    tune_coarse_en = tune_we && (mode == HRCB_TUNE_FULL);
  end

  // ----------------------------------------------------------------------
  // compensation and gain per channel pair
  // ----------------------------------------------------------------------
  // a tuning update lands after a same-cycle host write, so the engine's
  // value wins; the host sees it on the next read
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < 2; i++) begin
        comp_lo_r[i] <= HRCB_RST_COMP_LO;
        gain_r[i]    <= HRCB_RST_GAIN;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && reg_addr == (HRCB_ADDR_COMP_LO_A + 8'(i))) begin
          comp_lo_r[i] <= reg_wdata;
        end
        if (reg_wr && reg_addr == (HRCB_ADDR_GAIN_A + 8'(i))) begin
          gain_r[i] <= reg_wdata;
        end
        if (tune_pair_b == (i == 1)) begin
          if (tune_comp_en) begin
            comp_lo_r[i] <= tune_comp[7:0];
            gain_r[i][HRCB_COMP_HI_MSB:HRCB_COMP_HI_LSB] <=
              tune_comp[9:8];
          end
          if (tune_coarse_en) begin
            gain_r[i][HRCB_COARSE_MSB:HRCB_COARSE_LSB] <=
              tune_coarse;
          end
          if (tune_fine_en) begin
            gain_r[i][HRCB_FINE_MSB:HRCB_FINE_LSB] <= tune_fine;
          end
        end
      end
    end
  end

  always_comb begin
    pair_a_comp   = {gain_r[0][HRCB_COMP_HI_MSB:HRCB_COMP_HI_LSB],
                     comp_lo_r[0]};
    pair_a_coarse = gain_r[0][HRCB_COARSE_MSB:HRCB_COARSE_LSB];
    pair_a_fine   = gain_r[0][HRCB_FINE_MSB:HRCB_FINE_LSB];
    pair_b_comp   = {gain_r[1][HRCB_COMP_HI_MSB:HRCB_COMP_HI_LSB],
                     comp_lo_r[1]};
    pair_b_coarse = gain_r[1][HRCB_COARSE_MSB:HRCB_COARSE_LSB];
    pair_b_fine   = gain_r[1][HRCB_FINE_MSB:HRCB_FINE_LSB];
  end

  // ----------------------------------------------------------------------
  // angle sign flags
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      octant_r    <= 2'h0;
      ratio_neg_r <= 1'b0;
      den_neg_r   <= 1'b0;
      num_neg_r   <= 1'b0;
    end else if (calc_valid) begin
      octant_r    <= calc_octant;
      ratio_neg_r <= calc_ratio_neg;
      den_neg_r   <= calc_den_neg;
      num_neg_r   <= calc_num_neg;
    end
  end

  // only the invert bit takes a host write
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      invert_r <= 1'b0;
    end else if (reg_wr && reg_addr == HRCB_ADDR_SIGN) begin
      invert_r <= reg_wdata[HRCB_INVERT_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      angle_dir <= 1'b0;
    end else if (calc_valid) begin
      angle_dir <= calc_dir_raw ^ invert_r;
    end
  end

  assign dir_invert = invert_r;

  // ----------------------------------------------------------------------
  // phase constants, filter, interval, wake settings
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sine_r     <= HRCB_RST_SINE;
      cosine_r   <= HRCB_RST_COSINE;
      beta_r     <= HRCB_RST_BETA;
      wake_r     <= HRCB_RST_WAKE;
      interval_r <= HRCB_RST_INTERVAL;
    end else if (reg_wr) begin
      unique case (reg_addr)
        HRCB_ADDR_SINE:     sine_r     <= reg_wdata;
        HRCB_ADDR_COSINE:   cosine_r   <= reg_wdata;
        HRCB_ADDR_BETA:     beta_r     <= reg_wdata;
        HRCB_ADDR_WAKE:     wake_r     <= reg_wdata;
        HRCB_ADDR_INTERVAL: interval_r <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  assign sine_const   = sine_r;
  assign cosine_const = cosine_r;
  assign interval_deg = interval_r;

  // out-of-range sizes are kept as written but flagged unusable
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      interval_ok <= 1'b0;
    end else begin
      interval_ok <= (interval_r >= HRCB_INTERVAL_MIN) &&
                     (interval_r <= HRCB_INTERVAL_MAX);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      filt_coeff <= HRCB_RST_BETA;
    end else if (filt_restart) begin
      filt_coeff <= beta_r;
    end
  end

  // ----------------------------------------------------------------------
  // wheel offset result
  // ----------------------------------------------------------------------
  // a result past one turn is a calculation fault; keep the last good one
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      offset_r <= HRCB_RST_OFFSET;
    end else if (offset_valid && offset_in <= HRCB_OFFSET_MAX) begin
      offset_r <= offset_in;
    end
  end

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      HRCB_ADDR_COMP_LO_A: rdata_nxt = comp_lo_r[0];
      HRCB_ADDR_COMP_LO_B: rdata_nxt = comp_lo_r[1];
      HRCB_ADDR_GAIN_A:    rdata_nxt = gain_r[0];
      HRCB_ADDR_GAIN_B:    rdata_nxt = gain_r[1];
      HRCB_ADDR_SIGN:      rdata_nxt = {1'b0, octant_r, 1'b0, invert_r,
                                        ratio_neg_r, den_neg_r,
                                        num_neg_r};
      HRCB_ADDR_SINE:      rdata_nxt = sine_r;
      HRCB_ADDR_COSINE:    rdata_nxt = cosine_r;
      HRCB_ADDR_BETA:      rdata_nxt = beta_r;
      HRCB_ADDR_WAKE:      rdata_nxt = wake_r;
      HRCB_ADDR_INTERVAL:  rdata_nxt = interval_r;
      HRCB_ADDR_OFFS_HI:   rdata_nxt = offset_r[15:8];
      HRCB_ADDR_OFFS_LO:   rdata_nxt = offset_r[7:0];
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // movement timer tick divider
  // ----------------------------------------------------------------------
  logic [15:0] div_r;
  logic        tick_r;

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == 16'(TICK_CYCLES - 1)) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // wheel wake unit
  // ----------------------------------------------------------------------
  hrcb_wake_if wk ();

  assign wk.threshold = wake_r[HRCB_THR_MSB:HRCB_THR_LSB];
  assign wk.preload   = wake_r[HRCB_PRE_MSB:HRCB_PRE_LSB];
  assign wk.mode_en   = wake_mode_en;

  hrcb_wheel_wake u_wake (
    .clk       (sys_clk),
    .rst_n     (rst_n_r),
    .tick      (tick_r),
    .move      (wheel_move),
    .touch     (touch_channel_zero),
    .sleep_req (wheel_sleep_req),
    .w         (wk.unit)
  );

  assign awake_r      = wk.awake;
  assign wake_r_pulse = wk.wake_pulse;
  assign wheel_awake  = awake_r;
  assign wheel_wake   = wake_r_pulse;

endmodule : hrcb_top
`default_nettype wire

// ### rtl/hrcb_wake_if.sv
/*
  Link between the register bank and the wheel wake unit.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface hrcb_wake_if;
  logic [2:0] threshold;
  logic [4:0] preload;
  logic       mode_en;
  logic       awake;
  logic       wake_pulse;

  modport ctrl (output threshold, preload, mode_en,
                input  awake, wake_pulse);
  modport unit (input  threshold, preload, mode_en,
                output awake, wake_pulse);
endinterface : hrcb_wake_if
`default_nettype wire

// ### rtl/hrcb_wheel_wake.sv
/*
  Wheel wake unit: movement counter, movement timer and sleep state.
  Assumes tick is a one-cycle enable and all inputs share the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module hrcb_wheel_wake
  import hrcb_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // events
  input  wire logic tick,
  input  wire logic move,
  input  wire logic touch,
  input  wire logic sleep_req,
  // settings and status
  hrcb_wake_if.unit w
);

  hrcb_wake_state_t state_r;
  logic [4:0]       timer_r;
  logic [2:0]       count_r;
  logic [2:0]       count_nxt;
  logic             expired;
  logic             hit;
  logic             wake_now;
  logic [4:0]       awake_load;

  always_comb begin
    count_nxt  = count_r;
    if (move && count_r != HRCB_COUNT_MAX) begin
      count_nxt = count_r + 3'h1;
    end
    // a zero preload stops the timer, so it never expires
    expired    = (w.preload != 5'h00) && (timer_r == 5'h00);
    hit        = (count_nxt >= w.threshold);
    wake_now   = (w.mode_en && touch) || (hit && !expired);
    awake_load = (w.preload == 5'h00) ? HRCB_AWAKE_LOAD : w.preload;
  end

  // ----------------------------------------------------------------------
  // sleep state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= HRCB_AWAKE;
      w.wake_pulse <= 1'b0;
    end else begin
      w.wake_pulse <= 1'b0;
      unique case (state_r)
        HRCB_SLEEP: begin
          if (wake_now) begin
            state_r      <= HRCB_AWAKE;
            w.wake_pulse <= 1'b1;
          end
        end
        HRCB_AWAKE: begin
          if (sleep_req) begin
            state_r <= HRCB_SLEEP;
          end
        end
      endcase
    end
  end

  assign w.awake = state_r[1];

  // ----------------------------------------------------------------------
  // movement timer and counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= HRCB_AWAKE_LOAD;
      count_r <= 3'h0;
    end else if (state_r == HRCB_AWAKE || wake_now) begin
      timer_r <= awake_load;
      count_r <= 3'h0;
      if (state_r == HRCB_AWAKE && sleep_req) begin
        timer_r <= w.preload;
      end
    end else if (expired) begin
      timer_r <= w.preload;
      count_r <= 3'h0;
    end else begin
      count_r <= count_nxt;
      if (tick && w.preload != 5'h00) begin
        timer_r <= timer_r - 5'h01;
      end
    end
  end

endmodule : hrcb_wheel_wake
`default_nettype wire

// ### testbench/hrcb_checker.sv
/*
  Port assertions for the rotation sensor configuration bank.
  Assumes it is bound into hrcb_top and shares its clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module hrcb_checker
  import hrcb_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       tune_we,
  // bank outputs and their causes
  input wire logic [9:0] pair_a_comp,
  input wire logic [1:0] pair_a_coarse,
  input wire logic [3:0] pair_a_fine,
  input wire logic [7:0] sine_const,
  input wire logic [7:0] cosine_const,
  input wire logic       calc_valid,
  input wire logic       calc_dir_raw,
  input wire logic       dir_invert,
  input wire logic       angle_dir,
  input wire logic       filt_restart,
  input wire logic [7:0] filt_coeff,
  input wire logic [7:0] interval_deg,
  input wire logic       interval_ok,
  input wire logic       wheel_awake,
  input wire logic       wheel_wake
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence wake_once_s;
    wheel_wake ##1 !wheel_wake;
  endsequence

  gain_write_a: assert property (
    reg_wr && reg_addr == HRCB_ADDR_GAIN_A && !tune_we |=>
    {pair_a_comp[9:8], pair_a_coarse, pair_a_fine} == $past(reg_wdata))
    else $error("gain byte not stored");
  sine_write_a: assert property (
    reg_wr && reg_addr == HRCB_ADDR_SINE |=> sine_const == $past(reg_wdata))
    else $error("sine constant not stored");
  cos_write_a: assert property (
    reg_wr && reg_addr == HRCB_ADDR_COSINE |=>
    cosine_const == $past(reg_wdata))
    else $error("cosine constant not stored");
  dir_capture_a: assert property (
    calc_valid && !reg_wr |=> angle_dir == ($past(calc_dir_raw) ^ dir_invert))
    else $error("direction not inverted as set");
  invert_write_a: assert property (
    reg_wr && reg_addr == HRCB_ADDR_SIGN |=> dir_invert == $past(reg_wdata[3]))
    else $error("invert bit not kept");
  filt_hold_a: assert property (
    !filt_restart |=> $stable(filt_coeff))
    else $error("filter value moved without restart");
  interval_flag_a: assert property (
    1'b1 |=> interval_ok == ($past(interval_deg) >= HRCB_INTERVAL_MIN &&
                             $past(interval_deg) <= HRCB_INTERVAL_MAX))
    else $error("interval range flag wrong");
  wake_pulse_a: assert property (
    $rose(wheel_awake) |-> wake_once_s)
    else $error("wake pulse not one cycle");
endmodule : hrcb_checker
`default_nettype wire

bind hrcb_top hrcb_checker chk_u (.*);

// ### testbench/hrcb_host_model.sv
/*
  Host side of the byte register port: single writes and reads.
  Assumes the bank samples strobes on the rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module hrcb_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_wdata = 8'h00;
  end

  // idle lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'h1;
    @(negedge clk);
    reg_wr    = 1'h0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'h1;
    @(negedge clk);
    reg_rd   = 1'h0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd
endmodule : hrcb_host_model
`default_nettype wire

// ### testbench/test_hall_rotation_config_bank.sv
/*
  Self-checking bench for the rotation sensor configuration bank.
  Assumes hrcb_top with a shortened timer tick and the host model.
*/
`timescale 1ns/100ps
`default_nettype none
module test_hall_rotation_config_bank
  import hrcb_pkg::*;
;
  logic        sys_clk = 1'h0, arst_n = 1'h0;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic   reg_wr, reg_rd;
  logic [1:0]  tune_mode = 2'h0, tune_coarse = 2'h1, calc_octant = 2'h0;
  logic [3:0]  tune_fine = 4'h4;
  logic [9:0]  tune_comp = 10'h000;
  logic [15:0] offset_in = 16'h0000;
  logic        tune_we = 1'h0, tune_pair_b = 1'h0, calc_valid = 1'h0;
  logic        calc_ratio_neg = 1'h0, calc_den_neg = 1'h0;
  logic        calc_num_neg = 1'h0, calc_dir_raw = 1'h0;
  logic        filt_restart = 1'h0, offset_valid = 1'h0;
  logic        wake_mode_en = 1'h0, touch_channel_zero = 1'h0;
  logic        wheel_move = 1'h0, wheel_sleep_req = 1'h0;
  logic [9:0]  pair_a_comp, pair_b_comp, ec = 10'h35A;
  logic [1:0]  pair_a_coarse, pair_b_coarse, eco = 2'h2;
  logic [3:0]  pair_a_fine, pair_b_fine, ef = 4'h7;
  logic [7:0]  sine_const, cosine_const, filt_coeff, interval_deg;
  logic        dir_invert, angle_dir, interval_ok, wheel_awake, wheel_wake;
  int          err_total = 0, num_checks = 0, cyc = 0;
  // address, written byte, byte read back
  logic [23:0] rows [13] = '{24'h745A5A, 24'h75A5A5, 24'h76E7E7, 24'h779C9C,
    24'h78FF08, 24'h798080, 24'h7AB4B4, 24'h7B2121, 24'h7C4242, 24'h7D2D2D,
    24'h7E5500, 24'h7FAA00, 24'h601100};
  logic [8:0]  ivals [4] = '{9'h012, 9'h015, 9'h169, 9'h16A};

  hrcb_host_model host_u (.clk(sys_clk), .reg_addr, .reg_wr, .reg_rd,
                          .reg_wdata, .reg_rdata);
  hrcb_top #(.TICK_CYCLES(4)) dut_u (.*);

  always #2 sys_clk = ~sys_clk;

  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(16'(d), 16'(e));
  endtask : rdchk

  task automatic pulse(ref logic s, input int n);
    @(negedge sys_clk);
    s = 1'h1;
    repeat (n) @(negedge sys_clk);
    s = 1'h0;
  endtask : pulse

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (4) @(negedge sys_clk);
    arst_n = 1'h1;
    repeat (3) @(negedge sys_clk);
    foreach (rows[i]) begin
      host_u.wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
    end
    chk({pair_a_comp, pair_a_coarse, pair_a_fine}, 16'hD6A7);
    chk({pair_b_comp, pair_b_coarse, pair_b_fine}, 16'hA95C);
    chk({sine_const, cosine_const}, 16'h80B4);
    chk({interval_deg, 7'h00, interval_ok}, 16'h2D01);
    for (int m = 0; m < 4; m++) begin
      tune_mode = 2'(m);
      tune_comp = 10'h0C0 + 10'(m);
      pulse(tune_we, 1);
      if (m != 0) ec = tune_comp;
      if (m >= 2) ef = tune_fine;
      if (m == 3) eco = tune_coarse;
      chk({pair_a_comp, pair_a_coarse, pair_a_fine}, {ec, eco, ef});
    end
    for (int o = 0; o < 4; o++) begin
      calc_octant = 2'(o);
      calc_dir_raw = o[0];
      {calc_ratio_neg, calc_den_neg, calc_num_neg} = 3'(o + 3);
      pulse(calc_valid, 1);
      chk(16'(angle_dir), 16'(!o[0]));
      rdchk(HRCB_ADDR_SIGN, {1'h0, 2'(o), 2'h1, 3'(o + 3)});
    end
    host_u.wr(HRCB_ADDR_SIGN, 8'h00);
    rdchk(HRCB_ADDR_SIGN, 8'h66);
    chk(16'(dir_invert), 16'h0000);
    for (int i = 0; i < 2; i++) begin
      offset_in = 16'h0167 + 16'(i);
      pulse(offset_valid, 1);
      rdchk(HRCB_ADDR_OFFS_HI, 8'h01);
      rdchk(HRCB_ADDR_OFFS_LO, 8'h67);
    end
    foreach (ivals[i]) begin
      host_u.wr(HRCB_ADDR_INTERVAL, ivals[i][8:1]);
      @(negedge sys_clk);
      chk(16'(interval_ok), 16'(ivals[i][0]));
    end
    chk(16'(filt_coeff), 16'h0008);
    pulse(filt_restart, 1);
    chk(16'(filt_coeff), 16'h0021);
    pulse(wheel_sleep_req, 1);
    chk(16'(wheel_awake), 16'h0000);
    pulse(wheel_move, 2);
    chk(16'(wheel_wake), 16'h0001);
    @(negedge sys_clk);
    chk(16'(wheel_awake), 16'h0001);
    chk(16'(wheel_wake), 16'h0000);
    pulse(wheel_sleep_req, 1);
    pulse(wheel_move, 1);
    repeat (20) @(negedge sys_clk);
    pulse(wheel_move, 1);
    repeat (20) @(negedge sys_clk);
    chk(16'(wheel_awake), 16'h0000);
    host_u.wr(HRCB_ADDR_WAKE, 8'h40);
    pulse(wheel_move, 1);
    repeat (40) @(negedge sys_clk);
    pulse(wheel_move, 1);
    @(negedge sys_clk);
    chk(16'(wheel_awake), 16'h0001);
    host_u.wr(HRCB_ADDR_WAKE, 8'hE0);
    pulse(wheel_sleep_req, 1);
    for (int t = 0; t < 2; t++) begin
      wake_mode_en = t[0];
      pulse(touch_channel_zero, 1);
      @(negedge sys_clk);
      chk(16'(wheel_awake), 16'(t));
    end
    // second reset in mid-run brings back the power-up values
    arst_n = 1'h0;
    repeat (4) @(negedge sys_clk);
    arst_n = 1'h1;
    repeat (3) @(negedge sys_clk);
    chk({filt_coeff, interval_deg}, {HRCB_RST_BETA, HRCB_RST_INTERVAL});
    rdchk(HRCB_ADDR_WAKE, HRCB_RST_WAKE);
    rdchk(HRCB_ADDR_GAIN_A, HRCB_RST_GAIN);
    stop_test;
  end
endmodule : test_hall_rotation_config_bank
`default_nettype wire
